// >>> hw/dcr_device_capability.sv
// What this block does
// - Slot power message payload bits 9:8 load captured scale at bits 27:26.
// - Slot power message payload bits 7:0 load captured value at bits 25:18.
// - Scale codes 00,01,10,11 mean 1.0, 0.1, 0.01, 0.001.
// - Bits 31:28 always read zero.
// - Bits 17:15 always read 000b.
// - Power lamp, alert lamp and alert button present bits read zero.
// - Bits 11:9 follow the deep idle setting, control register bits 15:13.
// - Deep idle tolerance resets to 110b, 32 to 64 microseconds.
// - From the first clock after reset, deep idle tolerance is never below the PHY L1 exit need sampled at the last clock edge.
// - Bits 8:6 follow the light idle setting, control register bits 18:16.
// - Light idle tolerance resets to 110b, 2 to 4 microseconds.
// - From the first clock after reset, light idle tolerance is never below the PHY L0s exit need sampled at the last clock edge.
// - Wide tag supported bit 5 reads zero.
// - Ghost function field bits 4:3 reads 00b.
// - Max payload supported bits 2:0 read 010b, 512 bytes.
// - Register at offset 94h, resets to 00000D82h, writes change nothing.
`timescale 1ns/100ps
module dcr_device_capability (
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire dcr_pkg::dcr_cfg_req_type cfg_req,
	output logic                          cfg_ack,
	output logic                          cfg_hit,
	output logic [31:0]                   cfg_rdata,
	output logic                          cfg_write_ignored,
	input  wire dcr_pkg::dcr_spl_msg_type spl_msg,
	input  wire logic [2:0]               deep_idle_exit_setting,
	input  wire logic [2:0]               light_idle_exit_setting,
	input  wire logic [2:0]               deep_idle_phy_floor,
	input  wire logic [2:0]               light_idle_phy_floor,
	output dcr_pkg::dcr_scale_type        captured_power_scale,
	output logic [7:0]                    captured_power_value,
	output logic                          spl_captured,
	output logic                          deep_idle_clamped,
	output logic                          light_idle_clamped
);

	// -------------------------------------------------------------
	// Address decode
	// -------------------------------------------------------------
	// Only the dword part of the address is compared; byte enables
	// are not used at all, so they never move the register.
	function automatic logic dcr_addr_hit(input logic [11:0] addr);
		dcr_addr_hit = (addr[11:2] == dcr_pkg::DCR_OFFSET[11:2]);
	endfunction

	// Builds the register image from the live field sources.
	function automatic dcr_pkg::dcr_reg_type dcr_compose(
		input dcr_pkg::dcr_scale_type scale,
		input logic [7:0]             value,
		input logic [2:0]             deep_tol,
		input logic [2:0]             light_tol
	);
		dcr_pkg::dcr_reg_type img;
		img                           = '0;
		img.rsvd_hi                   = dcr_pkg::DCR_RSVD_HI_VALUE;
		img.captured_power_scale      = scale;
		img.captured_power_value      = value;
		img.rsvd_mid                  = dcr_pkg::DCR_RSVD_MID_VALUE;
		img.power_lamp_present        = dcr_pkg::DCR_LAMP_ABSENT;
		img.alert_lamp_present        = dcr_pkg::DCR_LAMP_ABSENT;
		img.alert_button_present      = dcr_pkg::DCR_LAMP_ABSENT;
		img.deep_idle_exit_tolerance  = deep_tol;
		img.light_idle_exit_tolerance = light_tol;
		img.wide_tag_supported        = dcr_pkg::DCR_WIDE_TAG_VALUE;
		img.ghost_function_supported  = dcr_pkg::DCR_GHOST_FUNC_VALUE;
		img.max_payload_supported     = dcr_pkg::DCR_MAX_PAYLOAD_512;
		dcr_compose                   = img;
	endfunction

	// -------------------------------------------------------------
	// Hardware-updated fields
	// -------------------------------------------------------------
	dcr_pkg::dcr_scale_type scale_q;
	logic [7:0]             value_q;
	logic                   capture_q;
	logic [2:0]             deep_tol_q;
	logic [2:0]             light_tol_q;
	logic                   deep_clamp_q;
	logic                   light_clamp_q;

	dcr_power_capture u_power_capture (
		.clock                (clock),
		.rst_n                (rst_n),
		.spl_msg              (spl_msg),
		.captured_power_scale (scale_q),
		.captured_power_value (value_q),
		.capture_pulse        (capture_q)
	);

	// The setting inputs come from the general control register on this
	// clock, so they are used without synchronisers.
	dcr_exit_tolerance #(
		.RESET_CODE (dcr_pkg::DCR_DEEP_IDLE_RESET)
	) u_deep_idle (
		.clock     (clock),
		.rst_n     (rst_n),
		.setting   (deep_idle_exit_setting),
		.phy_floor (deep_idle_phy_floor),
		.tolerance (deep_tol_q),
		.clamped   (deep_clamp_q)
	);

	dcr_exit_tolerance #(
		.RESET_CODE (dcr_pkg::DCR_LIGHT_IDLE_RESET)
	) u_light_idle (
		.clock     (clock),
		.rst_n     (rst_n),
		.setting   (light_idle_exit_setting),
		.phy_floor (light_idle_phy_floor),
		.tolerance (light_tol_q),
		.clamped   (light_clamp_q)
	);

	// -------------------------------------------------------------
	// Configuration access sequencer
	// -------------------------------------------------------------
	// One access is answered in the cycle after it is taken; the answer
	// cycle refuses new requests, so accesses are at least two apart.
	dcr_pkg::dcr_state_type state_r;
	dcr_pkg::dcr_state_type state_nxt;
	logic                   ack_r;
	logic                   ack_nxt;
	logic                   hit_r;
	logic                   hit_nxt;
	logic [31:0]            rdata_r;
	logic [31:0]            rdata_nxt;
	logic                   wign_r;
	logic                   wign_nxt;
	dcr_pkg::dcr_reg_type   image;
	logic                   req_hit;

	always_comb begin
		image   = dcr_compose(scale_q, value_q, deep_tol_q, light_tol_q);
		req_hit = dcr_addr_hit(cfg_req.addr);
	end

	always_comb begin
		state_nxt = state_r;
		ack_nxt   = 1'b0;
		hit_nxt   = 1'b0;
		rdata_nxt = dcr_pkg::DCR_READ_MISS;
		wign_nxt  = 1'b0;
		unique case (state_r)
			dcr_pkg::DCR_ST_IDLE: begin
				if (cfg_req.valid) begin
					state_nxt = dcr_pkg::DCR_ST_RESPOND;
					ack_nxt   = 1'b1;
					hit_nxt   = req_hit;
					if (!cfg_req.write && req_hit) begin
						rdata_nxt = image;
					end
					// Writes are acknowledged and dropped.
					wign_nxt = cfg_req.write && req_hit;
				end
			end
			dcr_pkg::DCR_ST_RESPOND: begin
				state_nxt = dcr_pkg::DCR_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= dcr_pkg::DCR_ST_IDLE;
			ack_r   <= 1'b0;
			hit_r   <= 1'b0;
			rdata_r <= dcr_pkg::DCR_READ_MISS;
			wign_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ack_r   <= ack_nxt;
			hit_r   <= hit_nxt;
			rdata_r <= rdata_nxt;
			wign_r  <= wign_nxt;
		end
	end

	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------
	assign cfg_ack              = ack_r;
	assign cfg_hit              = hit_r;
	assign cfg_rdata            = rdata_r;
	assign cfg_write_ignored    = wign_r;
	assign captured_power_scale = scale_q;
	assign captured_power_value = value_q;
	assign spl_captured         = capture_q;
	assign deep_idle_clamped    = deep_clamp_q;
	assign light_idle_clamped   = light_clamp_q;

endmodule

// >>> hw/dcr_pkg.sv
package dcr_pkg;

	// -------------------------------------------------------------
	// Register placement and reset image
	// -------------------------------------------------------------
	localparam logic [11:0] DCR_OFFSET      = 12'h094;
	localparam logic [31:0] DCR_RESET_VALUE = 32'h00000d82;
	localparam logic [31:0] DCR_READ_MISS   = 32'h00000000;

	// -------------------------------------------------------------
	// Field values fixed in hardware
	// -------------------------------------------------------------
	localparam logic [3:0] DCR_RSVD_HI_VALUE    = 4'h0;
	localparam logic [2:0] DCR_RSVD_MID_VALUE   = 3'h0;
	localparam logic       DCR_LAMP_ABSENT      = 1'h0;
	localparam logic       DCR_WIDE_TAG_VALUE   = 1'h0;
	localparam logic [1:0] DCR_GHOST_FUNC_VALUE = 2'h0;
	localparam logic [2:0] DCR_MAX_PAYLOAD_512  = 3'h2;

	// -------------------------------------------------------------
	// Reset values of the hardware-updated fields
	// -------------------------------------------------------------
	localparam logic [1:0] DCR_SCALE_RESET       = 2'h0;
	localparam logic [7:0] DCR_VALUE_RESET       = 8'h00;
	localparam logic [2:0] DCR_DEEP_IDLE_RESET   = 3'h6;
	localparam logic [2:0] DCR_LIGHT_IDLE_RESET  = 3'h6;

	// -------------------------------------------------------------
	// Positions inside the slot power limit message payload
	// -------------------------------------------------------------
	localparam int DCR_PAYLOAD_SCALE_MSB = 9;
	localparam int DCR_PAYLOAD_SCALE_LSB = 8;
	localparam int DCR_PAYLOAD_VALUE_MSB = 7;
	localparam int DCR_PAYLOAD_VALUE_LSB = 0;

	// -------------------------------------------------------------
	// Types
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		DCR_SCALE_1_0   = 2'b00,
		DCR_SCALE_0_1   = 2'b01,
		DCR_SCALE_0_01  = 2'b10,
		DCR_SCALE_0_001 = 2'b11
	} dcr_scale_type;

	typedef enum logic [0:0] {
		DCR_ST_IDLE    = 1'b0,
		DCR_ST_RESPOND = 1'b1
	} dcr_state_type;

	// Bit order of the struct is the register layout, MSB first.
	typedef struct packed {
		logic [3:0]    rsvd_hi;
		dcr_scale_type captured_power_scale;
		logic [7:0]    captured_power_value;
		logic [2:0]    rsvd_mid;
		logic          power_lamp_present;
		logic          alert_lamp_present;
		logic          alert_button_present;
		logic [2:0]    deep_idle_exit_tolerance;
		logic [2:0]    light_idle_exit_tolerance;
		logic          wide_tag_supported;
		logic [1:0]    ghost_function_supported;
		logic [2:0]    max_payload_supported;
	} dcr_reg_type;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} dcr_cfg_req_type;

	typedef struct packed {
		logic       valid;
		logic [9:0] payload;
	} dcr_spl_msg_type;

endpackage

// >>> hw/dcr_power_capture.sv
`timescale 1ns/100ps
module dcr_power_capture (
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire dcr_pkg::dcr_spl_msg_type spl_msg,
	output dcr_pkg::dcr_scale_type        captured_power_scale,
	output logic [7:0]                    captured_power_value,
	output logic                          capture_pulse
);

	// -------------------------------------------------------------
	// Capture of the slot power limit message
	// -------------------------------------------------------------
	dcr_pkg::dcr_scale_type scale_r;
	dcr_pkg::dcr_scale_type scale_nxt;
	logic [7:0]             value_r;
	logic [7:0]             value_nxt;
	logic                   pulse_r;
	logic                   pulse_nxt;

	// Only the message path and reset load these fields; nothing else reaches them.
	always_comb begin
		scale_nxt = scale_r;
		value_nxt = value_r;
		pulse_nxt = 1'b0;
		if (spl_msg.valid) begin
			scale_nxt = dcr_pkg::dcr_scale_type'(spl_msg.payload[dcr_pkg::DCR_PAYLOAD_SCALE_MSB:
				dcr_pkg::DCR_PAYLOAD_SCALE_LSB]);
			value_nxt = spl_msg.payload[dcr_pkg::DCR_PAYLOAD_VALUE_MSB:
				dcr_pkg::DCR_PAYLOAD_VALUE_LSB];
			pulse_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scale_r <= dcr_pkg::dcr_scale_type'(dcr_pkg::DCR_SCALE_RESET);
			value_r <= dcr_pkg::DCR_VALUE_RESET;
			pulse_r <= 1'b0;
		end else begin
			scale_r <= scale_nxt;
			value_r <= value_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign captured_power_scale = scale_r;
	assign captured_power_value = value_r;
	assign capture_pulse        = pulse_r;

endmodule

// >>> hw/dcr_exit_tolerance.sv
`timescale 1ns/100ps
module dcr_exit_tolerance #(
	parameter logic [2:0] RESET_CODE = 3'h6
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [2:0] setting,
	input  wire logic [2:0] phy_floor,
	output logic [2:0]      tolerance,
	output logic            clamped
);

	// -------------------------------------------------------------
	// Tolerance tracking with a floor
	// -------------------------------------------------------------
	// Larger codes mean longer acceptable latency, so the floor is a
	// plain maximum. A setting below the floor is held at the floor.
	logic [2:0] tol_r;
	logic [2:0] tol_nxt;
	logic       clamp_r;
	logic       clamp_nxt;

	always_comb begin
		clamp_nxt = (setting < phy_floor);
		tol_nxt   = clamp_nxt ? phy_floor : setting;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tol_r   <= RESET_CODE;
			clamp_r <= 1'b0;
		end else begin
			tol_r   <= tol_nxt;
			clamp_r <= clamp_nxt;
		end
	end

	assign tolerance = tol_r;
	assign clamped   = clamp_r;

endmodule

// >>> test/dcr_device_capability_properties.sv
`timescale 1ns/100ps
module dcr_device_capability_properties (
	input wire logic                     clock,
	input wire logic                     rst_n,
	input wire dcr_pkg::dcr_cfg_req_type cfg_req,
	input wire logic                     cfg_ack,
	input wire logic                     cfg_hit,
	input wire logic [31:0]              cfg_rdata,
	input wire logic                     cfg_write_ignored,
	input wire dcr_pkg::dcr_spl_msg_type spl_msg,
	input wire logic [2:0]               deep_idle_exit_setting,
	input wire logic [2:0]               light_idle_exit_setting,
	input wire logic [2:0]               deep_idle_phy_floor,
	input wire logic [2:0]               light_idle_phy_floor,
	input wire dcr_pkg::dcr_scale_type   captured_power_scale,
	input wire logic [7:0]               captured_power_value,
	input wire logic                     spl_captured,
	input wire logic                     deep_idle_clamped,
	input wire logic                     light_idle_clamped
);
	// ----------------------------------------------------------
	// Decodes
	// ----------------------------------------------------------
	logic       hit_c;
	logic       take_c;
	logic       rd_c;
	logic       deep_lt;
	logic       light_lt;
	logic       fix_c;
	logic [9:0] pwr_c;
	logic [9:0] pay_c;
	assign hit_c    = cfg_req.addr[11:2] == 10'h025;
	assign take_c   = cfg_req.valid && !cfg_ack;
	assign rd_c     = cfg_ack && cfg_hit && !cfg_write_ignored;
	assign deep_lt  = deep_idle_exit_setting < deep_idle_phy_floor;
	assign light_lt = light_idle_exit_setting < light_idle_phy_floor;
	assign pwr_c    = {captured_power_scale, captured_power_value};
	assign pay_c    = spl_msg.payload;
	assign fix_c    = {cfg_rdata[31:28], cfg_rdata[17:12], cfg_rdata[5:0]} == 16'h0002;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_ack_after_take: assert property (take_c |=> cfg_ack && cfg_hit == $past(hit_c))
		else $error("no answer or wrong hit");
	a_ack_one_cycle: assert property (cfg_ack |=> !cfg_ack)
		else $error("answer longer than one cycle");
	a_write_flag: assert property (take_c && cfg_req.write |=> cfg_write_ignored == $past(hit_c))
		else $error("write flag wrong");
	a_write_no_data: assert property (cfg_write_ignored |-> cfg_ack && cfg_rdata == 32'h0)
		else $error("write answer carries data");
	a_quiet_idle: assert property (!cfg_ack |-> !cfg_hit && cfg_rdata == 32'h0)
		else $error("answer lines active outside answer");
	a_read_fixed: assert property (rd_c |-> fix_c)
		else $error("fixed field wrong");
	a_read_power: assert property (rd_c |-> cfg_rdata[27:18] == $past(pwr_c))
		else $error("read power field wrong");
	a_spl_load: assert property (spl_msg.valid |=> pwr_c == $past(pay_c) && spl_captured)
		else $error("message not captured");
	a_spl_hold: assert property (!spl_msg.valid |=> $stable(pwr_c) && !spl_captured)
		else $error("power field changed without message");
	a_deep_clamp: assert property (1'b1 |=> deep_idle_clamped == $past(deep_lt))
		else $error("deep clamp wrong");
	a_light_clamp: assert property (1'b1 |=> light_idle_clamped == $past(light_lt))
		else $error("light clamp wrong");
	c_read_hit: cover property (rd_c);
	c_write_hit: cover property (cfg_write_ignored);
	c_deep_clamp: cover property (deep_idle_clamped);
endmodule
bind dcr_device_capability dcr_device_capability_properties u_props (.clock, .rst_n, .cfg_req,
	.cfg_ack, .cfg_hit, .cfg_rdata, .cfg_write_ignored, .spl_msg, .deep_idle_exit_setting,
	.light_idle_exit_setting, .deep_idle_phy_floor, .light_idle_phy_floor,
	.captured_power_scale, .captured_power_value, .spl_captured, .deep_idle_clamped,
	.light_idle_clamped);

// >>> test/dcr_host_model.sv
`timescale 1ns/100ps
module dcr_host_model (
	input  wire logic                clock,
	input  wire logic                cfg_ack,
	input  wire logic                cfg_hit,
	input  wire logic [31:0]         cfg_rdata,
	input  wire logic                cfg_write_ignored,
	output dcr_pkg::dcr_cfg_req_type cfg_req,
	output dcr_pkg::dcr_spl_msg_type spl_msg
);
	initial begin
		cfg_req = '0;
		spl_msg = '0;
	end
	// ----------------------------------------------------------
	// Host actions
	// ----------------------------------------------------------
	// Released lines show inverted values so stale data is never mistaken for valid.
	task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic hit, output logic ign, output logic [31:0] rd, output logic ok);
		int n;
		n = 0;
		@(negedge clock);
		cfg_req = '{1'b1, wr, a, 4'hf, wd};
		do begin
			@(posedge clock);
			n++;
		end while (cfg_ack !== 1'b1 && n < 4);
		hit = cfg_hit;
		ign = cfg_write_ignored;
		rd = cfg_rdata;
		ok = cfg_ack;
		@(negedge clock);
		cfg_req = '{1'b0, ~wr, ~a, 4'h0, ~wd};
	endtask
	task automatic spl_send(input logic [9:0] p);
		@(negedge clock);
		spl_msg = '{1'b1, p};
	endtask
	task automatic spl_idle();
		@(negedge clock);
		spl_msg = '{1'b0, ~spl_msg.payload};
	endtask
endmodule

// >>> test/dcr_device_capability_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module dcr_device_capability_tb;
	logic                     clock = 1'b0;
	logic                     rst_n = 1'b0;
	dcr_pkg::dcr_cfg_req_type cfg_req;
	dcr_pkg::dcr_spl_msg_type spl_msg;
	logic                     cfg_ack;
	logic                     cfg_hit;
	logic                     cfg_write_ignored;
	logic [31:0]              cfg_rdata;
	logic [2:0]               dset = 3'h6;
	logic [2:0]               lset = 3'h6;
	logic [2:0]               dflr = 3'h0;
	logic [2:0]               lflr = 3'h0;
	logic                     h;
	logic                     w;
	logic                     ok;
	logic [31:0]              rd;
	logic [9:0]               pay;
	dcr_pkg::dcr_scale_type   pscale;
	logic [7:0]               pvalue;
	logic                     spl_cap;
	logic                     dclamp;
	logic                     lclamp;
	int                       seed = 5675;
	int                       n_mismatch = 0;
	int                       compares = 0;
	int                       cycles = 0;
	always #5 clock = ~clock;
	dcr_device_capability u_dcr_device_capability (.clock(clock), .rst_n(rst_n),
		.cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata),
		.cfg_write_ignored(cfg_write_ignored), .spl_msg(spl_msg),
		.deep_idle_exit_setting(dset), .light_idle_exit_setting(lset),
		.deep_idle_phy_floor(dflr), .light_idle_phy_floor(lflr),
		.captured_power_scale(pscale), .captured_power_value(pvalue), .spl_captured(spl_cap),
		.deep_idle_clamped(dclamp), .light_idle_clamped(lclamp));
	dcr_host_model u_host (.clock(clock), .cfg_ack(cfg_ack), .cfg_hit(cfg_hit),
		.cfg_rdata(cfg_rdata), .cfg_write_ignored(cfg_write_ignored), .cfg_req(cfg_req),
		.spl_msg(spl_msg));
	// ----------------------------------------------------------
	// Expectations and helpers
	// ----------------------------------------------------------
	function automatic logic [2:0] mx(input logic [2:0] a, input logic [2:0] b);
		return (a > b) ? a : b;
	endfunction
	function automatic logic [31:0] img(input logic [9:0] p);
		return {4'h0, p, 6'h00, mx(dset, dflr), mx(lset, lflr), 6'h02};
	endfunction
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic eh);
		u_host.access(1'b0, a, ~e, h, w, rd, ok);
		`CHK({ok, h, w}, {1'b1, eh, 1'b0})
		`CHK(rd, e)
	endtask
	task automatic end_sim();
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		repeat (2) @(posedge clock);
		@(negedge clock) rst_n = 1'b1;
		rd_chk(12'h094, 32'h00000d82, 1'b1);
		rd_chk(12'h097, 32'h00000d82, 1'b1);
		rd_chk(12'h098, 32'h0, 1'b0);
		rd_chk(12'h090, 32'h0, 1'b0);
		u_host.access(1'b1, 12'h094, 32'hffffffff, h, w, rd, ok);
		`CHK({ok, h, w, rd}, {3'b111, 32'h0})
		rd_chk(12'h094, 32'h00000d82, 1'b1);
		for (int i = 0; i < 40; i++) begin
			pay = 10'($random(seed));
			pay[9:8] = i[1:0];
			u_host.spl_send(pay);
			{dset, dflr, lset, lflr} = 12'($random(seed));
			if (i == 0)
				{dset, dflr, lset, lflr} = {3'h0, 3'h7, 3'h7, 3'h0};
			u_host.spl_idle();
			`CHK({spl_cap, pscale, pvalue, dclamp, lclamp}, {1'b1, pay, dset < dflr, lset < lflr})
			rd_chk(12'h094, img(pay), 1'b1);
		end
		u_host.spl_send(10'h155);
		u_host.spl_send(10'h2ab);
		u_host.spl_idle();
		`CHK({spl_cap, pscale, pvalue}, {1'b1, 10'h2ab})
		rd_chk(12'h094, img(10'h2ab), 1'b1);
		@(negedge clock) rst_n = 1'b0;
		{dset, dflr, lset, lflr} = {3'h6, 3'h0, 3'h6, 3'h0};
		@(negedge clock) rst_n = 1'b1;
		rd_chk(12'h094, 32'h00000d82, 1'b1);
		end_sim();
	end
endmodule
